// ### ctmc_pkg.sv
// shared constants for the capture timer mode control block
package ctmc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTMC_MODE_OFFSET    = 8'hbc;
  localparam logic [7:0] CTMC_COUNT_OFFSET   = 8'hc0;
  localparam logic [7:0] CTMC_FALLCAP_OFFSET = 8'hc4;
  localparam logic [7:0] CTMC_RISECAP_OFFSET = 8'hc8;
  localparam logic [7:0] CTMC_MODE_RESET     = 8'h00;
  localparam logic [7:0] CTMC_CAPTURE_RESET  = 8'h00;
  // ---------------------------------------------------------------
  // mode register fields
  // ---------------------------------------------------------------
  localparam int CTMC_FLAG_UPPER_BIT = 7;
  localparam int CTMC_FLAG_LOWER_BIT = 6;
  localparam int CTMC_OVF_IRQ_EN_BIT = 5;
  localparam int CTMC_EDGE_SEL_BIT   = 4;
  localparam int CTMC_CLEAR_LSB      = 2;
  localparam int CTMC_CLKSEL_LSB     = 0;
  // ---------------------------------------------------------------
  // field encodings and divide ratios
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CTMC_CLK_DIV64 = 2'h0,
    CTMC_CLK_DIV32 = 2'h1,
    CTMC_CLK_DIV2  = 2'h2,
    CTMC_CLK_SUB4  = 2'h3
  } ctmc_clksel_type;
  typedef enum logic [1:0] {
    CTMC_CLR_NONE = 2'h0,
    CTMC_CLR_FALL = 2'h1,
    CTMC_CLR_RISE = 2'h2,
    CTMC_CLR_BOTH = 2'h3
  } ctmc_clear_type;
  localparam int CTMC_DIV_SLOW   = 64;
  localparam int CTMC_DIV_MID    = 32;
  localparam int CTMC_DIV_FAST   = 2;
  localparam int CTMC_DIV_SUB    = 4;
  localparam logic [7:0] CTMC_COUNT_MAX = 8'hff;
endpackage

// ### ctmc_prescaler.sv
// count enable generator: system clock taps and divided sub-clock
`timescale 1ns/1ps
module ctmc_prescaler
  import ctmc_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstSyncN,
  // selection and sources
  input  wire ctmc_pkg::ctmc_clksel_type clockSel,
  input  wire logic                      subClock,
  // count enable
  output logic                           countTick
);
  import ctmc_pkg::*;

  // -------------------------------------------------------------
  // system clock divider
  // -------------------------------------------------------------
  localparam int DW = $clog2(CTMC_DIV_SLOW);
  logic [DW-1:0] divCount;
  logic [1:0]    subSync;
  logic          subPrev;
  logic [1:0]    subDiv;
  logic          subEdge;

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      divCount <= '0;
    end else begin
      divCount <= divCount + 1'b1;
    end
  end

  // -------------------------------------------------------------
  // sub-clock: sampled, so it must be well below the system rate
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      subSync <= 2'h0;
      subPrev <= 1'b0;
      subDiv  <= 2'h0;
    end else begin
      subSync <= {subSync[0], subClock};
      subPrev <= subSync[1];
      if (subEdge) begin
        subDiv <= subDiv + 1'b1;
      end
    end
  end

  assign subEdge = subSync[1] & ~subPrev;

  always_comb begin
    case (clockSel)
      CTMC_CLK_DIV64: countTick = (divCount == DW'(CTMC_DIV_SLOW - 1));
      CTMC_CLK_DIV32: countTick = (divCount[$clog2(CTMC_DIV_MID)-1:0] == 5'(CTMC_DIV_MID - 1));
      CTMC_CLK_DIV2:  countTick = (divCount[$clog2(CTMC_DIV_FAST)-1:0] == 1'(CTMC_DIV_FAST - 1));
      CTMC_CLK_SUB4:  countTick = subEdge && (subDiv == 2'(CTMC_DIV_SUB - 1));
      default:        countTick = 1'b0;
    endcase
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  AST_DIV64_SPACING: assert property (@(posedge clk) disable iff (!rstSyncN)
    (clockSel == CTMC_CLK_DIV64 && countTick) ##1 (clockSel == CTMC_CLK_DIV64) |-> !countTick[*8])
    else $error("divide-by-64 tick came too soon");
  AST_DIV2_RATE: assert property (@(posedge clk) disable iff (!rstSyncN)
    (clockSel == CTMC_CLK_DIV2) ##1 (clockSel == CTMC_CLK_DIV2) |-> countTick != $past(countTick))
    else $error("divide-by-2 tick not every other cycle");
endmodule

// ### ctmc_timer.sv
// capture timer: mode register, counter, edge clear, captures, overflow flags
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - clock select picks system clock over 64, 32, 2, or sub-clock over 4
// - clear field: never, falling edge, rising edge, or both capture edges clear counter
// - capture interrupt fires on rising edge when select is zero, falling when one
// - mode register resets to zero: divide-by-64, no clear, rising edge, no overflow irq
// - flags set on counter wrap; cleared only by zero write after reading one
// - overflow interrupt enable gates the overflow interrupt request
// - falling and rising edges copy the counter into separate read-only captures
module ctmc_timer
  import ctmc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // timer inputs
  input  wire logic       captureIn,
  input  wire logic       subClock,
  // interrupt requests
  output logic            captureIrq,
  output logic            overflowIrq
);
  import ctmc_pkg::*;

  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  logic [1:0] resetSync;
  logic       rstSyncN;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resetSync <= 2'h0;
    end else begin
      resetSync <= {resetSync[0], 1'b1};
    end
  end
  assign rstSyncN = resetSync[1];

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [1:0]      overflowFlag;
  logic [1:0]      flagArmed;
  logic            ovfIrqEnable;
  logic            edgeSelect;
  ctmc_clear_type  clearSource;
  ctmc_clksel_type clockSel;
  logic [7:0]      count;
  logic [7:0]      fallCapture;
  logic [7:0]      riseCapture;
  logic [1:0]      capSync;
  logic            capPrev;
  logic            riseEdge;
  logic            fallEdge;
  logic            clearEvent;
  logic            countTick;
  logic            wrap;
  logic            setupPhase;
  logic            accessDone;
  logic            modeWrite;
  logic            modeLoad;
  logic            mapped;

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = (addr == CTMC_MODE_OFFSET) || (addr == CTMC_COUNT_OFFSET) ||
               (addr == CTMC_FALLCAP_OFFSET) || (addr == CTMC_RISECAP_OFFSET);
  endfunction

  // -------------------------------------------------------------
  // apb decode: data is sampled in setup, so every access takes two cycles
  // -------------------------------------------------------------
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable;
  assign mapped     = isMapped(paddr);
  assign modeWrite  = accessDone && pwrite && (paddr == CTMC_MODE_OFFSET);
  assign modeLoad   = setupPhase && !pwrite && (paddr == CTMC_MODE_OFFSET);
  assign pready     = accessDone;
  assign pslverr    = accessDone && !mapped;

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      prdata <= 32'h0;
    end else if (setupPhase && !pwrite) begin
      case (paddr)
        CTMC_MODE_OFFSET:    prdata <= {24'h0, overflowFlag, 6'h00};
        CTMC_COUNT_OFFSET:   prdata <= {24'h0, count};
        CTMC_FALLCAP_OFFSET: prdata <= {24'h0, fallCapture};
        CTMC_RISECAP_OFFSET: prdata <= {24'h0, riseCapture};
        default:             prdata <= 32'h0;
      endcase
    end
  end

  // -------------------------------------------------------------
  // write-only control fields
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ovfIrqEnable <= CTMC_MODE_RESET[CTMC_OVF_IRQ_EN_BIT];
      edgeSelect   <= CTMC_MODE_RESET[CTMC_EDGE_SEL_BIT];
      clearSource  <= ctmc_clear_type'(CTMC_MODE_RESET[CTMC_CLEAR_LSB +: 2]);
      clockSel     <= ctmc_clksel_type'(CTMC_MODE_RESET[CTMC_CLKSEL_LSB +: 2]);
    end else if (modeWrite) begin
      ovfIrqEnable <= pwdata[CTMC_OVF_IRQ_EN_BIT];
      edgeSelect   <= pwdata[CTMC_EDGE_SEL_BIT];
      clearSource  <= ctmc_clear_type'(pwdata[CTMC_CLEAR_LSB +: 2]);
      clockSel     <= ctmc_clksel_type'(pwdata[CTMC_CLKSEL_LSB +: 2]);
    end
  end

  // -------------------------------------------------------------
  // overflow flags: a wrap in the clearing cycle keeps the flag set
  // -------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_flag
    localparam int BIT = CTMC_FLAG_LOWER_BIT + i;
    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        overflowFlag[i] <= CTMC_MODE_RESET[BIT];
      end else if (wrap) begin
        overflowFlag[i] <= 1'b1;
      end else if (modeWrite && !pwdata[BIT] && flagArmed[i]) begin
        overflowFlag[i] <= 1'b0;
      end
    end
    // armed with the very value loaded into prdata, so a wrap mid-read cannot arm or disarm
    always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
        flagArmed[i] <= 1'b0;
      end else if (modeLoad && overflowFlag[i]) begin
        flagArmed[i] <= 1'b1;
      end else if (modeWrite && !pwdata[BIT]) begin
        flagArmed[i] <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // capture input sync and edges
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      capSync <= 2'h0;
      capPrev <= 1'b0;
    end else begin
      capSync <= {capSync[0], captureIn};
      capPrev <= capSync[1];
    end
  end
  assign riseEdge = capSync[1] & ~capPrev;
  assign fallEdge = ~capSync[1] & capPrev;

  always_comb begin
    case (clearSource)
      CTMC_CLR_NONE: clearEvent = 1'b0;
      CTMC_CLR_FALL: clearEvent = fallEdge;
      CTMC_CLR_RISE: clearEvent = riseEdge;
      CTMC_CLR_BOTH: clearEvent = riseEdge | fallEdge;
      default:       clearEvent = 1'b0;
    endcase
  end

  // -------------------------------------------------------------
  // counter and captures: a clear beats a tick in the same cycle
  // -------------------------------------------------------------
  ctmc_prescaler u_prescaler (
    .clk       (clk),
    .rstSyncN  (rstSyncN),
    .clockSel  (clockSel),
    .subClock  (subClock),
    .countTick (countTick)
  );

  assign wrap = countTick && !clearEvent && (count == CTMC_COUNT_MAX);

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      count <= 8'h00;
    end else if (clearEvent) begin
      count <= 8'h00;
    end else if (countTick) begin
      count <= count + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      fallCapture <= CTMC_CAPTURE_RESET;
      riseCapture <= CTMC_CAPTURE_RESET;
    end else begin
      if (fallEdge) begin
        fallCapture <= count;
      end
      if (riseEdge) begin
        riseCapture <= count;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      captureIrq  <= 1'b0;
      overflowIrq <= 1'b0;
    end else begin
      captureIrq  <= edgeSelect ? fallEdge : riseEdge;
      overflowIrq <= wrap && ovfIrqEnable;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  sequence modeReadSetup;
    psel && !penable && !pwrite && (paddr == CTMC_MODE_OFFSET);
  endsequence
  sequence modeReadAccess;
    psel && penable && !pwrite && (paddr == CTMC_MODE_OFFSET);
  endsequence

  AST_CLEAR_ON_EDGE: assert property (@(posedge clk) disable iff (!rstSyncN)
    ((clearSource == CTMC_CLR_FALL && fallEdge) || (clearSource == CTMC_CLR_RISE && riseEdge)) |=> count == 8'h00)
    else $error("counter not cleared on selected edge");
  AST_NO_CLEAR: assert property (@(posedge clk) disable iff (!rstSyncN)
    (clearSource == CTMC_CLR_NONE && !countTick) |=> count == $past(count))
    else $error("counter moved without tick or clear");
  AST_CAPTURE_IRQ_EDGE: assert property (@(posedge clk) disable iff (!rstSyncN)
    ((!edgeSelect && riseEdge) || (edgeSelect && fallEdge)) |=> captureIrq)
    else $error("capture interrupt missed");
  AST_CAPTURE_IRQ_WRONG: assert property (@(posedge clk) disable iff (!rstSyncN)
    (!edgeSelect && fallEdge) |=> !captureIrq)
    else $error("capture interrupt on wrong edge");
  AST_FLAG_WRITE_ONE: assert property (@(posedge clk) disable iff (!rstSyncN)
    (modeWrite && (overflowFlag == 2'h3) && (pwdata[7:6] == 2'h3)) |=> overflowFlag == 2'h3)
    else $error("writing one changed a flag");
  AST_RESET_ZERO: assert property (@(posedge clk) disable iff (!rstSyncN)
    !$past(rstSyncN) |-> (overflowFlag == 2'h0) && !ovfIrqEnable && !edgeSelect &&
      (clearSource == CTMC_CLR_NONE) && (clockSel == CTMC_CLK_DIV64))
    else $error("mode register not zero after reset");
  AST_WRAP_SETS: assert property (@(posedge clk) disable iff (!rstSyncN)
    wrap |=> (overflowFlag == 2'h3) && (count == 8'h00))
    else $error("wrap did not set both flags");
  AST_UNARMED_KEEPS: assert property (@(posedge clk) disable iff (!rstSyncN)
    (modeWrite && overflowFlag[0] && !flagArmed[0]) |=> overflowFlag[0])
    else $error("flag cleared without prior read");
  AST_OVF_IRQ_GATE: assert property (@(posedge clk) disable iff (!rstSyncN)
    wrap |=> overflowIrq == $past(ovfIrqEnable))
    else $error("overflow request not gated by enable");
  AST_RISE_CAPTURE: assert property (@(posedge clk) disable iff (!rstSyncN)
    riseEdge |=> riseCapture == $past(count))
    else $error("rising capture wrong");
  AST_MODE_READBACK: assert property (@(posedge clk) disable iff (!rstSyncN)
    modeReadSetup ##1 modeReadAccess |-> prdata == {24'h0, $past(overflowFlag), 6'h00})
    else $error("mode readback layout wrong");
endmodule

// ### ctmc_capture_source.sv
// capture pin and sub-clock source facing the timer
`timescale 1ns/1ps
module ctmc_capture_source #(
  parameter int SUB_HALF = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // request from the bench
  input  wire logic wantLevel,
  // pins toward the timer
  output logic      captureIn,
  output logic      subClock
);
  int subCount;
  // ---------------------------------------------------------------
  // capture pin
  // ---------------------------------------------------------------
  // the pin only moves just after an edge, so edge spacing is exact in clk cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      captureIn <= 1'b0;
    end else begin
      captureIn <= wantLevel;
    end
  end
  // ---------------------------------------------------------------
  // sub-clock
  // ---------------------------------------------------------------
  // period of 2*SUB_HALF clk keeps it well below clk/2 for the two-flop sampler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      subCount <= 0;
      subClock <= 1'b0;
    end else if (subCount == SUB_HALF - 1) begin
      subCount <= 0;
      subClock <= ~subClock;
    end else begin
      subCount <= subCount + 1;
    end
  end
endmodule

// ### testbench.sv
// self-checking testbench for the capture timer mode control block
`timescale 1ns/1ps
module testbench;
  import ctmc_pkg::*;
  typedef struct {int kind; logic [32:0] val; string name;} ctmc_note_type;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic          clk, reset_n, psel, penable, pwrite, wantLevel, sel;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, lastData;
  logic          pready, pslverr, captureIn, subClock, captureIrq, overflowIrq;
  int            errTotal, comparisons, cyc, capCount, ovfCount, base, t0, ticks;
  int            div[4];
  ctmc_note_type notes[$];
  ctmc_note_type note;

  ctmc_timer i_ctmc_timer (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .captureIn(captureIn), .subClock(subClock), .captureIrq(captureIrq), .overflowIrq(overflowIrq));
  ctmc_capture_source #(.SUB_HALF(4)) i_ctmc_capture_source (.clk(clk), .reset_n(reset_n),
    .wantLevel(wantLevel), .captureIn(captureIn), .subClock(subClock));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [32:0] exp, input logic [32:0] seen);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // read results are judged here, in the order the driver noted them
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (captureIrq === 1'b1) capCount <= capCount + 1;
    if (overflowIrq === 1'b1) ovfCount <= ovfCount + 1;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      note = notes.pop_front();
      if (note.kind == 1) check(note.name, note.val, {25'h0, prdata[7:0] - lastData[7:0]});
      else if (note.kind == 0) check(note.name, note.val, {pslverr, prdata});
      lastData = prdata;
    end
  end
  // ---------------------------------------------------------------
  // bus and pin tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      errTotal++;
      giveVerdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // upper data bits are random: only the low byte may matter
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'($urandom()), d});
  endtask

  // kind 0 exact, 1 change since previous read, 2 recorded only
  task automatic rd(input logic [7:0] a, input int kind, input logic [32:0] v, input string nm);
    notes.push_back('{kind, v, nm});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic drive(input logic v, input int t);
    while (cyc < t) @(posedge clk);
    wantLevel <= v;
    repeat (10) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(70));
    div = '{CTMC_DIV_SLOW, CTMC_DIV_MID, CTMC_DIV_FAST, CTMC_DIV_SUB * 8};
    {reset_n, psel, penable, pwrite, wantLevel} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lastData = 32'h0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(CTMC_MODE_OFFSET, 0, 33'h0, "mode reset");
    rd(CTMC_FALLCAP_OFFSET, 0, 33'h0, "fall capture reset");
    rd(CTMC_RISECAP_OFFSET, 0, 33'h0, "rise capture reset");
    rd(8'hcc, 0, {1'b1, 32'h0}, "unmapped read");
    wr(CTMC_MODE_OFFSET, 8'hff);
    rd(CTMC_MODE_OFFSET, 0, 33'h0, "mode write-only bits");
    $display("test reset and access done");
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 4; c++) begin
        sel = k[0] ^ c[0];
        wr(CTMC_MODE_OFFSET, {3'h0, sel, c[1:0], k[1:0]});
        repeat ($urandom_range(63)) @(posedge clk);
        // a clearing edge leaves one cycle fewer of counting before the next capture
        ticks = 320 / div[k];
        base = capCount;
        t0 = cyc;
        drive(1'b1, t0);
        check("capture irq on rise", 33'(!sel), 33'(capCount - base));
        rd(CTMC_RISECAP_OFFSET, 2, 33'h0, "rise capture");
        t0 = t0 + 320 + c[1];
        drive(1'b0, t0);
        rd(CTMC_FALLCAP_OFFSET, c[1] ? 0 : 1, 33'(ticks), "fall capture");
        t0 = t0 + 320 + c[0];
        drive(1'b1, t0);
        rd(CTMC_RISECAP_OFFSET, c[0] ? 0 : 1, 33'(ticks), "rise capture");
        drive(1'b0, t0 + 40);
        $display("test clock %0d clear %0d done", k, c);
      end
    end
    wr(CTMC_MODE_OFFSET, 8'h22);
    base = ovfCount;
    repeat (1100) @(posedge clk);
    check("overflow irq enabled", 33'h1, 33'(ovfCount - base >= 2));
    wr(CTMC_MODE_OFFSET, 8'h02);
    // a wrap in the write cycle itself may still raise one request
    repeat (2) @(posedge clk);
    base = ovfCount;
    repeat (1100) @(posedge clk);
    check("overflow irq masked", 33'h0, 33'(ovfCount - base));
    wr(CTMC_MODE_OFFSET, 8'h00);
    rd(CTMC_MODE_OFFSET, 0, 33'hc0, "flags kept without read");
    wr(CTMC_MODE_OFFSET, 8'h00);
    rd(CTMC_MODE_OFFSET, 0, 33'h0, "flags cleared");
    $display("test overflow flags done");
    repeat (5) @(posedge clk);
    giveVerdict();
  end

  initial begin
    repeat (100000) @(posedge clk);
    errTotal++;
    giveVerdict();
  end
endmodule
